// File: design/adcc_defs.vh
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ADCC_IDX_GIC      8'h0b
`define ADCC_IDX_PIR      8'h0c
`define ADCC_IDX_RESH     8'h1e
`define ADCC_IDX_CTRL     8'h1f
`define ADCC_IDX_PIE      8'h8c
`define ADCC_IDX_RESL     8'h9e
`define ADCC_IDX_CFG      8'h9f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADCC_CS_HI        7
`define ADCC_CS_LO        6
`define ADCC_CH_HI        5
`define ADCC_CH_LO        3
`define ADCC_GO_BIT       2
`define ADCC_ON_BIT       0
`define ADCC_FMT_BIT      7
`define ADCC_PCFG_HI      3
`define ADCC_PCFG_LO      0
`define ADCC_DONE_BIT     6
`define ADCC_IE_BIT       6
`define ADCC_GIE_BIT      7
`define ADCC_PERIPHERAL_IRQ_ENABLE_BIT     6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCC_RST_CTRL     8'h00
`define ADCC_RST_CFG      8'h00
`define ADCC_RST_PIR      8'h00
`define ADCC_RST_PIE      8'h00
`define ADCC_RST_GIC      8'h00

// ----------------------------------------------------------------
// Clock select codes and timing counts
// ----------------------------------------------------------------
`define ADCC_CS_2         2'b00
`define ADCC_CS_8         2'b01
`define ADCC_CS_32        2'b10
`define ADCC_CS_RC        2'b11
`define ADCC_DIV2_TOP     5'd1
`define ADCC_DIV8_TOP     5'd7
`define ADCC_DIV32_TOP    5'd31
`define ADCC_TOSC_PER_TCY 4
`define ADCC_TCY_M1       3'd3
`define ADCC_LAST_TAD     4'd10
`define ADCC_WAIT_M1      4'd1

`endif

// File: design/adcc_sync.v
`timescale 1ns/100ps
`default_nettype none

module adcc_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;

endmodule // adcc_sync

`default_nettype wire

// File: design/adcc_tad_gen.v
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_tad_gen (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       clear_i,
  input  wire [1:0] sel_i,
  input  wire       rc_tick_i,
  output wire       tick_o
);

  reg  [4:0] cnt_q;
  reg  [4:0] top;

  // ----------------------------------------------------------------
  // Divider top per select code
  // ----------------------------------------------------------------
  always @* begin
    case (sel_i)
      `ADCC_CS_2:  top = `ADCC_DIV2_TOP;
      `ADCC_CS_8:  top = `ADCC_DIV8_TOP;
      default:     top = `ADCC_DIV32_TOP;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      cnt_q <= 5'h00;
    end else if (cnt_q >= top) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  assign tick_o = (sel_i == `ADCC_CS_RC) ? rc_tick_i : (cnt_q >= top);

endmodule // adcc_tad_gen

`default_nettype wire

// File: design/adcc_top.v
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_top (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       wb_cyc_i,
  input  wire       wb_stb_i,
  input  wire       wb_we_i,
  input  wire [9:0] wb_adr_i,
  input  wire       wb_sel_i,
  input  wire [7:0] wb_dat_i,
  output wire [7:0] wb_dat_o,
  output wire       wb_ack_o,
  input  wire       sleep_i,
  input  wire [7:0] pin_i,
  input  wire       cmp_i,
  input  wire       rc_osc_i,
  output wire [7:0] port_read_o,
  output wire [2:0] channel_o,
  output wire       sample_o,
  output wire [9:0] dac_code_o,
  output wire       converter_on_o,
  output wire       busy_o,
  output wire       wake_o
);

  // ----------------------------------------------------------------
  // States, reset values and functions
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_DLY   = 3'd1;
  localparam [2:0] ST_SEG1  = 3'd2;
  localparam [2:0] ST_BITS  = 3'd3;
  localparam [2:0] ST_WAIT2 = 3'd4;
  localparam [7:0] RST_CTRL = `ADCC_RST_CTRL;
  localparam [7:0] RST_CFG  = `ADCC_RST_CFG;
  localparam [7:0] RST_PIR  = `ADCC_RST_PIR;
  localparam [7:0] RST_PIE  = `ADCC_RST_PIE;
  localparam [7:0] RST_GIC  = `ADCC_RST_GIC;

  // Analog (or reference) pin mask per port configuration
  function [7:0] analog_mask;
    input [3:0] cfg;
    begin
      case (cfg)
        4'h0, 4'h1, 4'h8: analog_mask = 8'hff;
        4'h2, 4'h3, 4'hc: analog_mask = 8'h1f;
        4'h4, 4'h5:       analog_mask = 8'h0b;
        4'h6, 4'h7:       analog_mask = 8'h00;
        4'h9, 4'ha, 4'hb: analog_mask = 8'h3f;
        4'hd:             analog_mask = 8'h0f;
        4'he:             analog_mask = 8'h01;
        default:          analog_mask = 8'h0d;
      endcase
    end
  endfunction

  // One successive approximation step: decide bit, try next lower
  function [9:0] sar_step;
    input [9:0] sar;
    input [3:0] k;
    input       keep;
    begin
      sar_step = sar;
      sar_step[4'd9 - k] = keep;
      if (k < 4'd9)
        sar_step[4'd8 - k] = 1'b1;
    end
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers and registers
  // ----------------------------------------------------------------
  wire [9:0] sync_q;
  wire [7:0] pin_s;
  wire       cmp_s;
  wire       rc_s;
  reg        rc_prev_q;
  wire       rc_tick = rc_s & ~rc_prev_q;

  adcc_sync #(
    .W (10)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({rc_osc_i, cmp_i, pin_i}),
    .q_o   (sync_q)
  );

  assign pin_s   = sync_q[7:0];
  assign cmp_s   = sync_q[8];
  assign rc_s    = sync_q[9];

  reg [2:0] state_q;
  reg [1:0] cs_q;
  reg [2:0] ch_q;
  reg       go_q;
  reg       on_q;
  reg       fmt_q;
  reg [3:0] pcfg_q;
  reg       done_q;
  reg       ie_q;
  reg       gie_q;
  reg       peripheral_irq_enable_q;
  reg [9:0] sar_q;
  reg [3:0] cnt_q;
  reg [2:0] tcy_q;
  reg       sample_q;
  reg       active_q;
  reg       wake_q;
  reg [7:0] port_q;
  reg [7:0] resh_q;
  reg [7:0] resl_q;
  reg [7:0] dat_q;
  reg       ack_q;
  reg [7:0] rd_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [7:0] idx      = wb_adr_i[9:2];
  wire       bus_req  = wb_cyc_i & wb_stb_i;
  wire       wr       = bus_req & wb_we_i & wb_sel_i & ack_q;
  wire       wr_ctrl  = wr & (idx == `ADCC_IDX_CTRL);
  wire       wr_cfg   = wr & (idx == `ADCC_IDX_CFG);
  wire       wr_pir   = wr & (idx == `ADCC_IDX_PIR);
  wire       wr_pie   = wr & (idx == `ADCC_IDX_PIE);
  wire       wr_gic   = wr & (idx == `ADCC_IDX_GIC);
  wire       wr_resh  = wr & (idx == `ADCC_IDX_RESH);
  wire       wr_resl  = wr & (idx == `ADCC_IDX_RESL);

  // ----------------------------------------------------------------
  // Conversion control terms
  // ----------------------------------------------------------------
  wire       tad_tick;
  wire       busy      = (state_q >= ST_DLY) && (state_q <= ST_BITS);
  wire       sleep_off = sleep_i & (cs_q != `ADCC_CS_RC);
  wire       go_clear  = wr_ctrl & ~wb_dat_i[`ADCC_GO_BIT];
  wire       off_write = wr_ctrl & ~wb_dat_i[`ADCC_ON_BIT];
  wire       abort     = busy & (go_clear | off_write | ~on_q |
                         sleep_off);
  wire       start     = (state_q == ST_IDLE) & wr_ctrl & on_q &
                         wb_dat_i[`ADCC_GO_BIT] & wb_dat_i[`ADCC_ON_BIT] &
                         ~sleep_off;
  wire       conv_end  = (state_q == ST_BITS) & tad_tick &
                         (cnt_q == `ADCC_LAST_TAD) & ~abort & ~rst_i;
  wire       tad_clear = start | abort | ((state_q == ST_DLY) &&
                         (tcy_q == `ADCC_TCY_M1));
  wire [15:0] result   = fmt_q ? {6'h00, sar_q} : {sar_q, 6'h00};

  adcc_tad_gen u_tad (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .clear_i   (tad_clear),
    .sel_i     (cs_q),
    .rc_tick_i (rc_tick),
    .tick_o    (tad_tick)
  );

  // ----------------------------------------------------------------
  // Control registers and sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= ST_IDLE;
      cs_q      <= RST_CTRL[`ADCC_CS_HI:`ADCC_CS_LO];
      ch_q      <= RST_CTRL[`ADCC_CH_HI:`ADCC_CH_LO];
      go_q      <= RST_CTRL[`ADCC_GO_BIT];
      on_q      <= RST_CTRL[`ADCC_ON_BIT];
      fmt_q     <= RST_CFG[`ADCC_FMT_BIT];
      pcfg_q    <= RST_CFG[`ADCC_PCFG_HI:`ADCC_PCFG_LO];
      done_q    <= RST_PIR[`ADCC_DONE_BIT];
      ie_q      <= RST_PIE[`ADCC_IE_BIT];
      gie_q     <= RST_GIC[`ADCC_GIE_BIT];
      peripheral_irq_enable_q    <= RST_GIC[`ADCC_PERIPHERAL_IRQ_ENABLE_BIT];
      sar_q     <= 10'h000;
      cnt_q     <= 4'h0;
      tcy_q     <= 3'h0;
      rc_prev_q <= 1'b0;
    end else begin
      rc_prev_q <= rc_s;

      if (wr_ctrl) begin
        cs_q <= wb_dat_i[`ADCC_CS_HI:`ADCC_CS_LO];
        ch_q <= wb_dat_i[`ADCC_CH_HI:`ADCC_CH_LO];
        on_q <= wb_dat_i[`ADCC_ON_BIT];
      end
      if (wr_cfg) begin
        fmt_q  <= wb_dat_i[`ADCC_FMT_BIT];
        pcfg_q <= wb_dat_i[`ADCC_PCFG_HI:`ADCC_PCFG_LO];
      end
      if (wr_pie) begin
        ie_q <= wb_dat_i[`ADCC_IE_BIT];
      end
      if (wr_gic) begin
        gie_q  <= wb_dat_i[`ADCC_GIE_BIT];
        peripheral_irq_enable_q <= wb_dat_i[`ADCC_PERIPHERAL_IRQ_ENABLE_BIT];
      end

      // Hardware set wins over a software clear
      if (conv_end) begin
        done_q <= 1'b1;
      end else if (wr_pir) begin
        done_q <= wb_dat_i[`ADCC_DONE_BIT];
      end

      if (abort) begin
        state_q <= ST_WAIT2;
        go_q    <= 1'b0;
        cnt_q   <= 4'h0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (start) begin
              go_q  <= 1'b1;
              tcy_q <= 3'h0;
              if (cs_q == `ADCC_CS_RC) begin
                state_q <= ST_DLY;
              end else begin
                state_q <= ST_SEG1;
              end
            end
          end
          ST_DLY: begin
            tcy_q <= tcy_q + 3'h1;
            if (tcy_q == `ADCC_TCY_M1) begin
              state_q <= ST_SEG1;
              tcy_q   <= 3'h0;
            end
          end
          ST_SEG1: begin
            if (tcy_q != `ADCC_TCY_M1) begin
              tcy_q <= tcy_q + 3'h1;
            end
            if (tad_tick && (tcy_q == `ADCC_TCY_M1)) begin
              state_q <= ST_BITS;
              sar_q   <= 10'h200;
              cnt_q   <= 4'h0;
            end
          end
          ST_BITS: begin
            if (tad_tick) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q < `ADCC_LAST_TAD) begin
                sar_q <= sar_step(sar_q, cnt_q, cmp_s);
              end
              if (cnt_q == `ADCC_LAST_TAD) begin
                go_q    <= 1'b0;
                state_q <= ST_WAIT2;
                cnt_q   <= 4'h0;
              end
            end
          end
          ST_WAIT2: begin
            if (tad_tick) begin
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == `ADCC_WAIT_M1) begin
                state_q <= ST_IDLE;
                cnt_q   <= 4'h0;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Result pair, never reset
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (conv_end) begin
      resh_q <= result[15:8];
      resl_q <= result[7:0];
    end else begin
      if (wr_resh) begin
        resh_q <= wb_dat_i;
      end
      if (wr_resl) begin
        resl_q <= wb_dat_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog side and status outputs
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sample_q <= 1'b0;
      active_q <= 1'b0;
      wake_q   <= 1'b0;
      port_q   <= 8'h00;
    end else begin
      sample_q <= (state_q == ST_IDLE) & on_q & ~sleep_off;
      active_q <= on_q & ~sleep_off;
      wake_q   <= sleep_i & done_q & ie_q;
      port_q   <= pin_s & ~analog_mask(pcfg_q);
    end
  end

  // ----------------------------------------------------------------
  // Wishbone read and acknowledge
  // ----------------------------------------------------------------
  always @* begin
    case (idx)
      `ADCC_IDX_CTRL: rd_d = {cs_q, ch_q, go_q, 1'b0, on_q};
      `ADCC_IDX_CFG:  rd_d = {fmt_q, 3'h0, pcfg_q};
      `ADCC_IDX_PIR:  rd_d = {1'b0, done_q, 6'h00};
      `ADCC_IDX_PIE:  rd_d = {1'b0, ie_q, 6'h00};
      `ADCC_IDX_GIC:  rd_d = {gie_q, peripheral_irq_enable_q, 6'h00};
      `ADCC_IDX_RESH: rd_d = resh_q;
      `ADCC_IDX_RESL: rd_d = resl_q;
      default:        rd_d = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 8'h00;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req && !ack_q) begin
        dat_q <= rd_d;
      end
    end
  end

  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = dat_q;
  assign port_read_o    = port_q;
  assign channel_o      = ch_q;
  assign sample_o       = sample_q;
  assign dac_code_o     = sar_q;
  assign converter_on_o = active_q;
  assign busy_o         = go_q;
  assign wake_o         = wake_q;

endmodule // adcc_top

`default_nettype wire

// File: test/adcc_top_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_top_chk (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [9:0] wb_adr_i,
  input  wire logic       wb_sel_i,
  input  wire logic [7:0] wb_dat_i,
  input  wire logic       wb_ack_o,
  input  wire logic       sleep_i,
  input  wire logic [7:0] port_read_o,
  input  wire logic       sample_o,
  input  wire logic       converter_on_o,
  input  wire logic       busy_o,
  input  wire logic       wake_o
);
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [9:0] len_q;
  logic       abort_q;
  wire        wr_w  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i;
  wire        ctl_w = wr_w & (wb_adr_i[9:2] == `ADCC_IDX_CTRL);
  wire        cfg_w = wr_w & (wb_adr_i[9:2] == `ADCC_IDX_CFG);
  wire        non_rc = ctrl_q[7:6] != `ADCC_CS_RC;

  // ----------------------------------------------------------------
  // Shadow of written settings, busy length
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h00;
      cfg_q  <= 8'h00;
    end else begin
      if (ctl_w) ctrl_q <= wb_dat_i;
      if (cfg_w) cfg_q <= wb_dat_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) begin
      len_q   <= 10'h000;
      abort_q <= 1'b0;
    end else begin
      len_q <= len_q + 10'h001;
      if ((ctl_w && !(wb_dat_i[2] && wb_dat_i[0])) || (sleep_i && non_rc))
        abort_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_wait2;
    !sample_o [*8] ##1 !sample_o [*8];
  endsequence
  sequence s_reacq;
    ##1 !sample_o ##1 sample_o;
  endsequence

  property p_reset_off;
    disable iff (1'b0) rst_i |=> !busy_o && !converter_on_o && !sample_o;
  endproperty
  property p_abort;
    ctl_w && !wb_dat_i[`ADCC_GO_BIT] && busy_o |-> ##[1:2] !busy_o;
  endproperty
  property p_post_wait;
    $fell(busy_o) && ctrl_q[7:6] == `ADCC_CS_8 && ctrl_q[0] && !sleep_i
      |-> s_wait2 ##0 s_reacq;
  endproperty
  property p_busy_hold;
    $rose(busy_o) |-> busy_o [*8];
  endproperty
  property p_length;
    $fell(busy_o) && !abort_q && ctrl_q[7:6] == `ADCC_CS_8
      |-> len_q >= 10'h060 && len_q <= 10'h062;
  endproperty
  property p_sleep_off;
    (sleep_i && non_rc) [*3] |-> !converter_on_o && !busy_o;
  endproperty
  property p_wake;
    wake_o |-> $past(sleep_i);
  endproperty
  property p_analog_read;
    cfg_q[3:1] == 3'h0 && $past(cfg_q[3:1]) == 3'h0 |-> port_read_o == 8'h00;
  endproperty

  a_reset_off: assert property (p_reset_off)
    else $error("reset left converter active");
  a_abort: assert property (p_abort)
    else $error("go clear did not stop conversion");
  a_post_wait: assert property (p_post_wait)
    else $error("acquisition restart timing wrong");
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  a_length: assert property (p_length)
    else $error("conversion length wrong");
  a_sleep_off: assert property (p_sleep_off)
    else $error("sleep did not power down");
  a_wake: assert property (p_wake)
    else $error("wake outside sleep");
  a_analog_read: assert property (p_analog_read)
    else $error("analog pin read nonzero");
endmodule // adcc_top_chk

`default_nettype wire

// File: test/adcc_analog_model.sv
`timescale 1ns/100ps
`default_nettype none

module adcc_analog_model (
  input  wire logic [79:0] level_i,
  input  wire logic [7:0]  pin_i,
  input  wire logic [7:0]  drive_i,
  input  wire logic [2:0]  channel_i,
  input  wire logic        sample_i,
  input  wire logic [9:0]  dac_i,
  output wire logic        cmp_o
);
  logic [9:0] mux_v;
  logic [9:0] hold_q;

  // Driven pin converts its own digital level
  always_comb begin
    if (drive_i[channel_i])
      mux_v = {10{pin_i[channel_i]}};
    else
      mux_v = level_i[channel_i*10 +: 10];
  end

  // Hold capacitor tracks only while sampling
  always_latch begin
    if (sample_i)
      hold_q = mux_v;
  end

  assign cmp_o = hold_q >= dac_i;
endmodule // adcc_analog_model

`default_nettype wire

// File: test/adc_conversion_control_test.sv
`timescale 1ns/100ps
`default_nettype none

module adc_conversion_control_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0;
  logic        slp = 1'b0, rc = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [7:0]  wd = 8'h00, pins = 8'hff, drv = 8'h00, rd_v;
  logic [79:0] lvl = {40'h0, 10'h155, 10'h2b7, 20'h0};
  logic [15:0] res;
  wire  [7:0]  dat_o, port_rd;
  wire  [9:0]  dac;
  wire  [2:0]  chan;
  wire         ack, smp, con, busy, wake, cmp;
  int          n_fail = 0, n_tests = 0, cyc_n = 0, n, t;
  logic [1:0]  cs_t[3] = '{2'h1, 2'h2, 2'h1};
  logic [2:0]  ch_t[3] = '{3'h2, 3'h3, 3'h5};
  logic        fm_t[3] = '{1'b1, 1'b0, 1'b1};
  logic [15:0] ex_t[3] = '{16'h02b7, 16'h5540, 16'h03ff};
  int          ln_t[3] = '{96, 384, 96};

  always #50 clk_i = ~clk_i;
  always #1133 rc = ~rc;

  adcc_top u_adcc_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .sleep_i(slp), .pin_i(pins),
    .cmp_i(cmp), .rc_osc_i(rc), .port_read_o(port_rd), .channel_o(chan),
    .sample_o(smp), .dac_code_o(dac), .converter_on_o(con),
    .busy_o(busy), .wake_o(wake));

  adcc_analog_model u_adcc_analog_model (
    .level_i(lvl), .pin_i(pins), .drive_i(drv), .channel_i(chan),
    .sample_i(smp), .dac_i(dac), .cmp_o(cmp));

  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 1'b1;
    adr <= {idx, 2'b00};
    wd  <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) n_fail++;
    rd_v = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx,
                     input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, rd_v});
  endtask

  task automatic rres();
    xfer(1'b0, 8'h1e, 8'h00);
    res[15:8] = rd_v;
    xfer(1'b0, 8'h9e, 8'h00);
    res[7:0] = rd_v;
  endtask

  task automatic wait_smp();
    t = 0;
    while (smp !== 1'b1 && t < 300) begin
      @(negedge clk_i);
      t++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("ctrl_rst", 8'h1f, 8'h00);
    rdc("cfg_rst", 8'h9f, 8'h00);
    rdc("pir_rst", 8'h0c, 8'h00);
    rdc("unmapped", 8'h40, 8'h00);
    chk("port_analog", 16'h0000, {8'h00, port_rd});
    wr(8'h9f, 8'h02);
    repeat (5) @(negedge clk_i);
    chk("port_mixed", 16'h00e0, {8'h00, port_rd});
    wr(8'h1e, 8'ha5);
    wr(8'h9e, 8'h3c);
    rres();
    chk("storage", 16'ha53c, res);
    for (int i = 0; i < 3; i++) begin
      drv <= (i == 2) ? 8'h20 : 8'h00;
      wr(8'h9f, {fm_t[i], 7'h00});
      wr(8'h1f, {cs_t[i], ch_t[i], 3'h1});
      wait_smp();
      repeat (20) @(posedge clk_i);
      wr(8'h1f, {cs_t[i], ch_t[i], 3'h5});
      n = 0;
      @(negedge clk_i);
      while (busy === 1'b1 && n < 2000) begin
        @(negedge clk_i);
        n++;
      end
      chk("conv_len", 16'h1, 16'(n >= ln_t[i] && n <= ln_t[i] + 2));
      rres();
      chk("result", ex_t[i], res);
      rdc("done_flag", 8'h0c, 8'h40);
      rdc("go_clear", 8'h1f, {cs_t[i], ch_t[i], 3'h1});
      wr(8'h0c, 8'h00);
    end
    drv <= 8'h00;
    wr(8'h9f, 8'h80);
    wr(8'h1f, 8'h51);
    wr(8'h1e, 8'h12);
    wr(8'h9e, 8'h34);
    wait_smp();
    wr(8'h1f, 8'h55);
    repeat (30) @(posedge clk_i);
    wr(8'h1f, 8'h51);
    repeat (3) @(negedge clk_i);
    chk("abort_busy", 16'h0, {15'h0, busy});
    rres();
    chk("abort_keep", 16'h1234, res);
    rdc("abort_flag", 8'h0c, 8'h00);
    wait_smp();
    chk("reacquire", 16'h1, {15'h0, smp});
    wr(8'h1f, 8'h55);
    repeat (10) @(posedge clk_i);
    slp <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk("sleep_pwr", 16'h0, {14'h0, con, busy});
    @(posedge clk_i);
    slp <= 1'b0;
    rdc("on_kept", 8'h1f, 8'h51);
    wr(8'h8c, 8'h40);
    wr(8'h1f, 8'hd1);
    wait_smp();
    wr(8'h1f, 8'hd5);
    slp <= 1'b1;
    t = 0;
    while (wake !== 1'b1 && t < 3000) begin
      @(negedge clk_i);
      t++;
    end
    chk("wake", 16'h1, {15'h0, wake});
    @(posedge clk_i);
    slp <= 1'b0;
    rres();
    chk("sleep_result", 16'h02b7, res);
    rdc("sleep_go", 8'h1f, 8'hd1);
    wr(8'h1f, 8'h51);
    wait_smp();
    wr(8'h1f, 8'h55);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("rst_busy", 16'h0, {15'h0, busy});
    rdc("rst_ctrl", 8'h1f, 8'h00);
    rdc("rst_cfg", 8'h9f, 8'h00);
    rres();
    chk("rst_keep", 16'h02b7, res);
    report_and_stop();
  end
endmodule // adc_conversion_control_test

bind adcc_top adcc_top_chk u_adcc_top_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .sleep_i(sleep_i), .port_read_o(port_read_o), .sample_o(sample_o),
  .converter_on_o(converter_on_o), .busy_o(busy_o), .wake_o(wake_o));

`default_nettype wire
